// *** hdl/phy_mgmt_pkg.sv ***
// Purpose: Shared constants and types for the per-channel management registers
// Assumes: Four channels, 16-bit registers, 5-bit register and PHY addresses
// Notes:   Every offset, bit position and reset value is named here once
package phy_mgmt_pkg;

    localparam int NCHAN = 4;

    // Register offsets
    localparam logic [4:0] REG_CONTROL   = 5'h00;
    localparam logic [4:0] REG_STATUS    = 5'h01;
    localparam logic [4:0] REG_ID_HIGH   = 5'h02;
    localparam logic [4:0] REG_ID_LOW    = 5'h03;
    localparam logic [4:0] REG_ADVERTISE = 5'h04;
    localparam logic [4:0] REG_PARTNER   = 5'h05;
    localparam logic [4:0] REG_EXPANSION = 5'h06;
    localparam logic [4:0] REG_NEXT_PAGE = 5'h07;
    localparam logic [4:0] REG_RSVD_LO   = 5'h08;
    localparam logic [4:0] REG_DEV_ONE   = 5'h1C;
    localparam logic [4:0] REG_DEV_TWO   = 5'h1D;
    localparam logic [4:0] REG_DEV_THREE = 5'h1E;
    localparam logic [4:0] REG_QUICK     = 5'h1F;

    // Control and status bit positions
    localparam int BIT_SOFT_RESET  = 15;
    localparam int BIT_LOOPBACK    = 14;
    localparam int BIT_SPEED       = 13;
    localparam int BIT_AN_ENABLE   = 12;
    localparam int BIT_POWER_DOWN  = 11;
    localparam int BIT_FLOAT       = 10;
    localparam int BIT_AN_RESTART  = 9;
    localparam int BIT_DUPLEX      = 8;
    localparam int BIT_COL_TEST    = 7;
    localparam int BIT_AN_COMPLETE = 5;

    // Reset values and the control write mask
    localparam logic [15:0] CONTROL_RST   = 16'h3000;
    localparam logic [15:0] CONTROL_WMASK = 16'h7F80;
    localparam logic [15:0] STATUS_RST    = 16'h7849;
    localparam logic [15:0] ADVERTISE_RST = 16'h01E1;
    localparam logic [15:0] NEXT_PAGE_RST = 16'h0000;
    localparam logic [15:0] DEV_TWO_RST   = 16'h1080;
    localparam logic [15:0] DEV_THREE_RST = 16'h0000;

    // Serial frame fields
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [3:0] HDR_LAST  = 4'hB;
    localparam logic [3:0] TA_LAST   = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hF;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  phy;
        logic [4:0]  register_address_field;
        logic [15:0] wdata;
    } req_t;

    typedef struct packed {
        logic speed;
        logic float_mode;
        logic duplex;
    } strap_t;

    typedef struct packed {
        logic loop_en;
        logic media_tx_en;
        logic media_rx_en;
        logic speed_select_bit;
        logic duplex_full;
        logic force_mode;
        logic an_enable;
        logic an_start;
        logic power_down;
        logic mii_out_en;
        logic col;
    } chan_cfg_t;

    // Registers that keep written values
    function automatic logic is_writable(input logic [4:0] a);
        return a == REG_CONTROL || a == REG_ADVERTISE || a == REG_NEXT_PAGE ||
               a == REG_DEV_TWO || a == REG_DEV_THREE;
    endfunction

endpackage

// *** hdl/mdio_frame.sv ***
// Purpose: Serial management frame engine, sampled in the mclk domain
// Assumes: mdc and mdio_i synchronous to mclk, mdc far slower than mclk
// Notes:   Bits taken on mdc rise, read data driven after mdc fall
`timescale 1ns/1ps
`default_nettype none
module mdio_frame (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire logic               mdc,
    input  wire logic               mdio_i,
    input  wire logic               hit,
    input  wire logic [15:0]        rdata,
    output var  phy_mgmt_pkg::req_t req,
    output logic                    mdio_o,
    output logic                    mdio_oe
);
    import phy_mgmt_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_START = 5'b00010,
        S_HDR   = 5'b00100,
        S_TA    = 5'b01000,
        S_DATA  = 5'b10000
    } state_t;

    state_t      st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [11:0] hdr_q, hdr_d;
    logic [15:0] sh_q, sh_d;
    logic        rd_q, rd_d, mdc_q, o_d, oe_d;
    req_t        req_d;
    logic        rise, fall;

    assign rise = mdc & ~mdc_q;
    assign fall = ~mdc & mdc_q;

    // Frame sequencing; header and data are MSB first
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        sh_d = sh_q;
        rd_d = rd_q;
        o_d = mdio_o;
        oe_d = mdio_oe;
        req_d = req;
        req_d.valid = 1'b0;
        if (rise) begin
            unique case (st_q)
                S_IDLE: if (!mdio_i) st_d = S_START;
                S_START: begin
                    st_d = mdio_i ? S_HDR : S_IDLE;
                    cnt_d = 4'h0;
                end
                S_HDR: begin
                    hdr_d = {hdr_q[10:0], mdio_i};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == HDR_LAST) begin
                        cnt_d = 4'h0;
                        st_d = S_TA;
                        rd_d = hdr_d[11:10] == OP_READ;
                        if (hdr_d[11:10] != OP_READ && hdr_d[11:10] != OP_WRITE) begin
                            st_d = S_IDLE;
                        end
                        req_d.phy = hdr_d[9:5];
                        req_d.register_address_field = hdr_d[4:0];
                        req_d.write = 1'b0;
                        req_d.valid = rd_d;
                    end
                end
                S_TA: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == TA_LAST) begin
                        cnt_d = 4'h0;
                        st_d = S_DATA;
                    end
                end
                S_DATA: begin
                    if (!rd_q) sh_d = {sh_q[14:0], mdio_i};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == DATA_LAST) begin
                        st_d = S_IDLE;
                        if (!rd_q) begin
                            req_d.valid = 1'b1;
                            req_d.write = 1'b1;
                            req_d.wdata = sh_d;
                        end
                    end
                end
                default: st_d = S_IDLE;
            endcase
        end else if (fall) begin
            // Drive only for a matching read; a foreign address stays silent
            if (st_q == S_TA && rd_q && cnt_q == TA_LAST) begin
                oe_d = hit;
                o_d = 1'b0;
                sh_d = rdata;
            end else if (st_q == S_DATA && rd_q) begin
                o_d = sh_q[15];
                sh_d = {sh_q[14:0], 1'b0};
            end else if (st_q == S_IDLE) begin
                oe_d = 1'b0;
                o_d = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q <= S_IDLE;
            cnt_q <= 4'h0;
            hdr_q <= 12'h000;
            sh_q <= 16'h0000;
            rd_q <= 1'b0;
            mdc_q <= 1'b0;
            req <= '0;
            mdio_o <= 1'b1;
            mdio_oe <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            mdc_q <= mdc;
            req <= req_d;
            mdio_o <= o_d;
            mdio_oe <= oe_d;
        end
    end
endmodule
`default_nettype wire

// *** hdl/chan_regs.sv ***
// Purpose: One channel's register copy and its mode outputs
// Assumes: Write strobe is one mclk cycle, already decoded to this channel
// Notes:   Straps are merged whenever reset or soft reset is active
`timescale 1ns/1ps
`default_nettype none
module chan_regs #(
    parameter logic [15:0] ID_HIGH = 16'h0000,
    parameter logic [15:0] ID_LOW  = 16'h0000
) (
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      clr,
    input  wire phy_mgmt_pkg::strap_t      strap,
    input  wire logic                      wr_en,
    input  wire logic [4:0]                register_address_field,
    input  wire logic [15:0]               wdata,
    input  wire logic                      an_done,
    input  wire logic                      tx_en,
    output logic [15:0]                    rdata,
    output var  phy_mgmt_pkg::chan_cfg_t   cfg
);
    import phy_mgmt_pkg::*;

    logic [15:0] ctrl_q, ctrl_d, adv_q, adv_d, np_q, np_d;
    logic [15:0] dev2_q, dev2_d, dev3_q, dev3_d;
    logic        done_q, done_d, pend_q, pend_d;
    chan_cfg_t   cfg_d;

    // Register updates, defaults, strap merge and self-clearing bits
    always_comb begin
        ctrl_d = ctrl_q;
        adv_d = adv_q;
        np_d = np_q;
        dev2_d = dev2_q;
        dev3_d = dev3_q;
        done_d = done_q;
        pend_d = pend_q;
        cfg_d = '0;
        if (!resetn || clr) begin
            ctrl_d = CONTROL_RST;
            ctrl_d[BIT_SPEED] = CONTROL_RST[BIT_SPEED] & strap.speed;
            ctrl_d[BIT_FLOAT] = CONTROL_RST[BIT_FLOAT] | strap.float_mode;
            ctrl_d[BIT_DUPLEX] = CONTROL_RST[BIT_DUPLEX] | strap.duplex;
            adv_d = ADVERTISE_RST;
            np_d = NEXT_PAGE_RST;
            dev2_d = DEV_TWO_RST;
            dev3_d = DEV_THREE_RST;
            done_d = 1'b0;
            pend_d = 1'b1;
        end else begin
            // Restart bit and powerup start both drop once the start fires
            ctrl_d[BIT_AN_RESTART] = 1'b0;
            pend_d = 1'b0;
            if (an_done) done_d = 1'b1;
            if (wr_en) begin
                // Read-only bits and reserved registers ignore writes
                unique case (register_address_field)
                    REG_CONTROL: begin
                        ctrl_d = wdata & CONTROL_WMASK;
                        if (wdata[BIT_AN_RESTART]) done_d = 1'b0;
                    end
                    REG_ADVERTISE: adv_d = wdata;
                    REG_NEXT_PAGE: np_d = wdata;
                    REG_DEV_TWO:   dev2_d = wdata;
                    REG_DEV_THREE: dev3_d = wdata;
                    default: ;
                endcase
            end
            cfg_d.loop_en = ctrl_q[BIT_LOOPBACK];
            cfg_d.media_tx_en = !ctrl_q[BIT_LOOPBACK] && !ctrl_q[BIT_POWER_DOWN];
            cfg_d.media_rx_en = !ctrl_q[BIT_LOOPBACK] && !ctrl_q[BIT_POWER_DOWN];
            cfg_d.speed_select_bit = ctrl_q[BIT_SPEED];
            cfg_d.duplex_full = ctrl_q[BIT_DUPLEX];
            cfg_d.force_mode = !ctrl_q[BIT_AN_ENABLE];
            cfg_d.an_enable = ctrl_q[BIT_AN_ENABLE];
            cfg_d.an_start = ctrl_q[BIT_AN_RESTART] | pend_q;
            cfg_d.power_down = ctrl_q[BIT_POWER_DOWN];
            cfg_d.mii_out_en = !ctrl_q[BIT_FLOAT];
            cfg_d.col = ctrl_q[BIT_COL_TEST] & tx_en;
        end
    end

    // Read view; bit 15 and bits 6:0 of control never hold ones
    always_comb begin
        rdata = 16'h0000;
        unique case (register_address_field)
            REG_CONTROL:   rdata = ctrl_q;
            REG_STATUS: begin
                rdata = STATUS_RST;
                rdata[BIT_AN_COMPLETE] = done_q;
            end
            REG_ID_HIGH:   rdata = ID_HIGH;
            REG_ID_LOW:    rdata = ID_LOW;
            REG_ADVERTISE: rdata = adv_q;
            REG_NEXT_PAGE: rdata = np_q;
            REG_DEV_TWO:   rdata = dev2_q;
            REG_DEV_THREE: rdata = dev3_q;
            default:       rdata = 16'h0000;
        endcase
    end

    // State registers
    always_ff @(posedge mclk) begin
        ctrl_q <= ctrl_d;
        adv_q <= adv_d;
        np_q <= np_d;
        dev2_q <= dev2_d;
        dev3_q <= dev3_d;
        done_q <= done_d;
        pend_q <= pend_d;
        cfg <= cfg_d;
    end
endmodule
`default_nettype wire

// *** hdl/phy_mgmt_control_regs.sv ***
// Purpose: Four-channel management register set behind the serial port
// Assumes: mdc, mdio_i, straps and tx_en synchronous to mclk
// Notes:   Channel selected by the low PHY address bits
//
// Notes on behaviour
// - Soft reset bit resets all channels, self-clears
// - Loopback stops media transmit and receive
// - Loopback path stops short of media sublayer
// - Speed bit applies only without autonegotiation
// - Speed bit loads default AND speed strap
// - Autonegotiation enable defaults to one
// - Powerdown stops transceivers, management still works
// - Isolate bit floats all MII outputs
// - Isolate bit loads default OR float strap
// - Autonegotiation starts by itself at powerup
// - Restart bit starts negotiation, clears complete flag
// - Duplex bit applies only without autonegotiation
// - Duplex bit loads default OR duplex strap
// - Collision test echoes transmit enable on collision
// - Control bits 6 to 0 read zero
// - Upper address bits match base, low pick channel
// - Five-bit register address, 16-bit data, MSB first
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_control_regs #(
    parameter logic [2:0]  PHY_BASE = 3'h0,
    parameter logic [15:0] ID_HIGH  = 16'h0A5A, // Arbitrary identity value
    parameter logic [15:0] ID_LOW   = 16'h5A00  // Arbitrary identity value
) (
    input  wire logic                                           mclk,
    input  wire logic                                           resetn,
    input  wire logic                                           mdc,
    input  wire logic                                           mdio_i,
    output logic                                                mdio_o,
    output logic                                                mdio_oe,
    input  wire logic                                           speed_strap_pin_d,
    input  wire logic                                           float_strap_pin_a,
    input  wire logic                                           duplex_strap_pin_d,
    input  wire logic [phy_mgmt_pkg::NCHAN-1:0]                 tx_en,
    input  wire logic [phy_mgmt_pkg::NCHAN-1:0]                 an_done,
    output var  phy_mgmt_pkg::chan_cfg_t [phy_mgmt_pkg::NCHAN-1:0] cfg
);
    import phy_mgmt_pkg::*;

    req_t        req;
    strap_t      strap;
    logic        hit;
    logic [1:0]  chan;
    logic [15:0] rdata_c [NCHAN];
    logic [NCHAN-1:0] wr_en;
    logic [15:0] rd_q, rd_d;
    logic        soft_q, soft_d;

    // Serial frame engine
    mdio_frame u_frame (
        .mclk    (mclk),
        .resetn  (resetn),
        .mdc     (mdc),
        .mdio_i  (mdio_i),
        .hit     (hit),
        .rdata   (rd_q),
        .req     (req),
        .mdio_o  (mdio_o),
        .mdio_oe (mdio_oe)
    );

    // Address match; channel copy chosen by the two low bits
    assign hit = req.phy[4:2] == PHY_BASE;
    assign chan = req.phy[1:0];
    assign strap = '{speed: speed_strap_pin_d, float_mode: float_strap_pin_a,
                     duplex: duplex_strap_pin_d};

    // One register copy per channel
    for (genvar i = 0; i < NCHAN; i++) begin : g_chan
        // Powerdown does not gate the strobe, so management keeps working
        assign wr_en[i] = req.valid && req.write && hit && chan == 2'(i);
        chan_regs #(
            .ID_HIGH (ID_HIGH),
            .ID_LOW  (ID_LOW)
        ) u_chan (
            .mclk    (mclk),
            .resetn  (resetn),
            .clr     (soft_q),
            .strap   (strap),
            .wr_en   (wr_en[i]),
            .register_address_field   (req.register_address_field),
            .wdata   (req.wdata),
            .an_done (an_done[i]),
            .tx_en   (tx_en[i]),
            .rdata   (rdata_c[i]),
            .cfg     (cfg[i])
        );
    end

    // Read capture and soft reset request; soft reset hits every channel
    always_comb begin
        rd_d = rd_q;
        soft_d = req.valid && req.write && hit && req.register_address_field == REG_CONTROL &&
                 req.wdata[BIT_SOFT_RESET];
        if (req.valid && !req.write) begin
            rd_d = hit ? rdata_c[chan] : 16'h0000;
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rd_q <= 16'h0000;
            soft_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            soft_q <= soft_d;
        end
    end

    // Helper strobes for the checks below; only the control write strobe is channel A
    logic wr_ctrl0, rd_ctrl, rd_rsvd;
    assign wr_ctrl0 = wr_en[0] && req.register_address_field == REG_CONTROL && !req.wdata[BIT_SOFT_RESET];
    assign rd_ctrl = req.valid && !req.write && hit && req.register_address_field == REG_CONTROL;
    assign rd_rsvd = req.valid && !req.write && req.register_address_field == REG_RSVD_LO;

    soft_reset_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (req.valid && req.write && hit && req.register_address_field == REG_CONTROL &&
         req.wdata[BIT_SOFT_RESET] && req.wdata[BIT_LOOPBACK] && !req.wdata[BIT_AN_ENABLE])
        |-> ##3 (cfg[3].an_enable && cfg[0].an_enable && !cfg[chan].loop_en)
    ) else $error("soft reset did not restore defaults");

    loop_media_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        cfg[0].loop_en |-> (!cfg[0].media_tx_en && !cfg[0].media_rx_en)
    ) else $error("media active during loopback");

    loop_path_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (wr_ctrl0 && req.wdata[BIT_LOOPBACK]) |-> ##2 cfg[0].loop_en
    ) else $error("loopback not entered after write");

    speed_force_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (wr_ctrl0 && !req.wdata[BIT_AN_ENABLE]) |->
        ##2 (cfg[0].force_mode && cfg[0].speed_select_bit == $past(req.wdata[BIT_SPEED], 2))
    ) else $error("forced speed not applied");

    speed_strap_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |=> cfg[0].speed_select_bit == $past(speed_strap_pin_d, 2)
    ) else $error("speed strap not merged at reset");

    an_default_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |=> (cfg[1].an_enable && !cfg[1].force_mode)
    ) else $error("autonegotiation not enabled after reset");

    power_down_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        cfg[0].power_down |-> !cfg[0].media_tx_en
    ) else $error("transmit active in powerdown");

    float_strap_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |=> cfg[2].mii_out_en == !$past(float_strap_pin_a, 2)
    ) else $error("float strap not merged at reset");

    powerup_start_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |=> cfg[0].an_start ##1 !cfg[0].an_start
    ) else $error("no single start pulse after reset");

    restart_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (wr_ctrl0 && req.wdata[BIT_AN_RESTART]) |-> ##2 cfg[0].an_start ##1 !cfg[0].an_start
    ) else $error("restart did not pulse once");

    duplex_strap_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |=> cfg[3].duplex_full == $past(duplex_strap_pin_d, 2)
    ) else $error("duplex strap not merged at reset");

    col_test_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        cfg[0].col |-> $past(tx_en[0])
    ) else $error("collision without transmit enable");

    ctrl_rsvd_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        rd_ctrl |=> (rd_q[6:0] == 7'h00 && !rd_q[BIT_SOFT_RESET])
    ) else $error("reserved control bits read nonzero");

    foreign_addr_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        (req.valid && !req.write && !hit) |=> rd_q == 16'h0000
    ) else $error("foreign address returned data");

    rsvd_read_a: assert property (
        @(posedge mclk) disable iff (!resetn)
        rd_rsvd |=> rd_q == 16'h0000
    ) else $error("reserved register read nonzero");

endmodule
`default_nettype wire

// *** test/mgmt_station.sv ***
// Purpose: Station management model driving serial frames on mdc and the data line
// Assumes: Data line is pulled up where nobody drives it, resolved in the bench
// Notes:   mdc high for 5 mclk, low for 6; mdc stands low between frames
`timescale 1ns/1ps
`default_nettype none
module mgmt_station (
    input  wire logic mclk,
    input  wire logic line,
    output logic      mdc,
    output logic      drv_en,
    output logic      drv_val
);
    initial begin
        mdc     = 1'b0;
        drv_en  = 1'b0;
        drv_val = 1'b1;
    end

    // One bit time; line sampled just before the rise, after device drove it
    task automatic bit_cycle(input logic en, input logic v, output logic smp);
        @(negedge mclk);
        drv_en  = en;
        drv_val = v;
        repeat (5) @(negedge mclk);
        smp = line;
        mdc = 1'b1;
        repeat (5) @(negedge mclk);
        mdc = 1'b0;
    endtask

    // Whole frame, MSB first, released during read turnaround and data
    task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        s;
        hdr = {2'b01, (wr ? 2'b01 : 2'b10), phy, ra};
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
        bit_cycle(wr, 1'b1, s);
        bit_cycle(wr, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wr, wd[i], s);
            rd[i] = s;
        end
        bit_cycle(1'b0, 1'b1, s);
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the four-channel management registers
// Assumes: Register model in integers, frames from the station model
// Notes:   Straps are random and re-drawn before the soft reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module tb_top;
    import phy_mgmt_pkg::*;
    localparam logic [15:0] IDH = 16'h1357; // Arbitrary identity value
    localparam logic [15:0] IDL = 16'h2468; // Arbitrary identity value
    logic            mclk = 1'b0;
    logic            resetn = 1'b0;
    logic            mdc, mdio_o, mdio_oe, drv_en, drv_val, line;
    logic [2:0]      strap = 3'h0;
    logic [3:0]      tx_en = 4'h0;
    logic [3:0]      an_done = 4'h0;
    logic [15:0]     rd;
    chan_cfg_t [3:0] cfg;
    int              err_count = 0;
    int              cmp_count = 0;
    int              regs [4][32];
    int              starts [4] = '{default: 0};
    int              prev [4];
    int              c, r, v, s;

    always #4 mclk = ~mclk;
    // Pull-up wins only where neither side drives
    assign line = mdio_oe ? mdio_o : (drv_en ? drv_val : 1'b1);

    phy_mgmt_control_regs #(.PHY_BASE(3'h0), .ID_HIGH(IDH), .ID_LOW(IDL)) u_dut (
        .mclk(mclk), .resetn(resetn), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .speed_strap_pin_d(strap[2]), .float_strap_pin_a(strap[1]),
        .duplex_strap_pin_d(strap[0]), .tx_en(tx_en), .an_done(an_done), .cfg(cfg));
    mgmt_station u_sme (.mclk(mclk), .line(line), .mdc(mdc), .drv_en(drv_en),
        .drv_val(drv_val));

    // Count negotiation start pulses per channel, mid-cycle to avoid the edge race
    always @(negedge mclk)
        if (resetn) for (int k = 0; k < 4; k++) if (cfg[k].an_start === 1'b1) starts[k]++;

    function automatic void model_reset();
        for (int k = 0; k < 4; k++) begin
            regs[k] = '{default: 0};
            regs[k][0] = 32'h1000 | (strap[2] << 13) | (strap[1] << 10) | (strap[0] << 8);
            regs[k][1] = 32'h7849;
            regs[k][2] = IDH;
            regs[k][3] = IDL;
            regs[k][4] = 32'h01E1;
            regs[k][29] = 32'h1080;
        end
    endfunction

    task automatic rw(input int wr, input int ch, input int ra, input int wv);
        u_sme.xfer(wr[0], {3'h0, ch[1:0]}, ra[4:0], wv[15:0], rd);
        if (wr != 0 && ra == 0) regs[ch][0] = wv & 32'h7D80;
        else if (wr != 0 && (ra == 4 || ra == 7 || ra == 29 || ra == 30)) regs[ch][ra] = wv;
        else if (wr == 0) `CHK(rd, 16'(regs[ch][ra]))
    endtask

    task automatic chk_cfg(input int ch);
        chan_cfg_t e;
        int        q;
        q = regs[ch][0];
        e = '{loop_en: q[14], media_tx_en: !(q[14] | q[11]), media_rx_en: !(q[14] | q[11]),
              speed_select_bit: q[13], duplex_full: q[8], force_mode: !q[12], an_enable: q[12],
              an_start: 1'b0, power_down: q[11], mii_out_en: !q[10], col: q[7] & tx_en[ch]};
        `CHK(cfg[ch], e)
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #700_000;
        err_count++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        s = $urandom(32'h0250bad0);
        strap = 3'($urandom);
        repeat (8) @(posedge mclk);
        @(negedge mclk) resetn = 1'b1;
        model_reset();
        repeat (4) @(negedge mclk);
        for (c = 0; c < 4; c++) `CHK(starts[c], 1)
        // Map scan after reset, registers spread over channels
        for (r = 0; r < 32; r++) rw(0, r % 4, r, 0);
        for (c = 0; c < 4; c++) chk_cfg(c);
        // Random writes to any place, read back
        for (int i = 0; i < 40; i++) begin
            c = $urandom % 4;
            r = (i < 12) ? 0 : $urandom % 32;
            v = $urandom & 32'h7DFF;
            rw(1, c, r, v);
            rw(0, c, r, 0);
            chk_cfg(c);
        end
        // Collision test, set in loopback only
        rw(1, 1, 0, 32'h4080);
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk) tx_en = 4'($urandom);
            @(negedge mclk);
            for (c = 0; c < 4; c++) chk_cfg(c);
        end
        tx_en = 4'h0;
        // Restart clears the complete flag and self-clears
        @(negedge mclk) an_done[3] = 1'b1;
        @(negedge mclk) an_done[3] = 1'b0;
        regs[3][1] = 32'h7869;
        rw(0, 3, 1, 0);
        s = starts[3];
        rw(1, 3, 0, regs[3][0] | 32'h0200);
        regs[3][1] = 32'h7849;
        rw(0, 3, 1, 0);
        rw(0, 3, 0, 0);
        `CHK(starts[3], s + 1)
        // Restart on channel A, forced mode and loopback at once
        rw(1, 0, 0, (regs[0][0] & 32'hEFFF) | 32'h4200);
        chk_cfg(0);
        // Foreign base address is neither stored nor answered
        u_sme.xfer(1'b1, 5'h1C, 5'h00, 16'h4000, rd);
        u_sme.xfer(1'b0, 5'h1C, 5'h00, 16'h0000, rd);
        `CHK(rd, 16'hFFFF)
        rw(0, 0, 0, 0);
        // Soft reset through one channel resets all four
        strap = 3'($urandom);
        prev = starts;
        // Loopback and forced mode ride along and must not survive the reset
        u_sme.xfer(1'b1, 5'h02, 5'h00, 16'hC000, rd);
        model_reset();
        repeat (4) @(negedge mclk);
        for (c = 0; c < 4; c++) begin
            `CHK(starts[c], prev[c] + 1)
            rw(0, c, 0, 0);
            rw(0, c, 4, 0);
            rw(0, c, 29, 0);
            chk_cfg(c);
        end
        complete_run();
    end
endmodule
`default_nettype wire
